// File: spi_ctl_consts.svh
// Constants for the serial control block: register indices, bit positions,
// reset values, divider ratios and a clock transition count.
// Assumes inclusion by bare name from the control block and the bench.
`ifndef SPI_CTL_CONSTS_SVH
`define SPI_CTL_CONSTS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define SPI_IDX_DATA 8'h21
`define SPI_IDX_CTRL 8'h22
`define SPI_IDX_STAT 8'h23

// ==========================================================================
// Control bit positions
`define SPI_CTRL_IRQ_EN 7
`define SPI_CTRL_PIN_EN 6
`define SPI_CTRL_RATE_HI 5
`define SPI_CTRL_MASTER 4
`define SPI_CTRL_IDLE_LVL 3
`define SPI_CTRL_PHASE 2
`define SPI_CTRL_RATE_MID 1
`define SPI_CTRL_RATE_LO 0

// ==========================================================================
// Status bit positions and reset values
`define SPI_STAT_DONE 7
`define SPI_STAT_WRITE_COLLISION_FLAG 6
`define SPI_STAT_MODE_FAULT_FLAG 4
`define SPI_CTRL_RESET 8'h00
`define SPI_DATA_RESET 8'h00

// ==========================================================================
// Serial clock divide ratios, indexed by {high, mid, low} rate bits
`define SPI_DIV_100 8'h02
`define SPI_DIV_000 8'h08
`define SPI_DIV_001 8'h10
`define SPI_DIV_110 8'h20
`define SPI_DIV_010 8'h40
`define SPI_DIV_011 8'h80

// ==========================================================================
// Clock transitions in one byte, minus one
`define SPI_LAST_EDGE 4'hf

`endif

// File: spi_ctl_pkg.sv
// Types shared by the serial control block.
// Assumes spi_ctl_consts.svh is on the include path.
`default_nettype none

package spi_ctl_pkg;

	// ======================================================================
	// Transfer engine states
	typedef enum logic [2:0] {
		XFER_IDLE = 3'b001,
		XFER_MASTER = 3'b010,
		XFER_SLAVE = 3'b100
	} xfer_state_t;

	// ======================================================================
	// Register selected by a bus address
	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_DATA = 2'b01,
		SEL_CTRL = 2'b10,
		SEL_STAT = 2'b11
	} reg_sel_t;

endpackage

`default_nettype wire

// File: sck_divider.sv
// Half-period tick generator for the master serial clock.
// Assumes half is held steady while run is high.
`timescale 1ns/1ps
`default_nettype none

module sck_divider #(
	parameter int W = 7
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic run, // Count while high, clear while low
	input wire logic [W-1:0] half, // Cycles per half period
	output logic tick // One-cycle pulse per half period
);

	logic [W-1:0] count;

	// ======================================================================
	// Half-period counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			count <= '0;
			tick <= 1'b0;
		end else if (count == half - W'(1)) begin
			count <= '0;
			tick <= 1'b1;
		end else begin
			count <= count + W'(1);
			tick <= 1'b0;
		end
	end

endmodule // sck_divider

`default_nettype wire

// File: spi_register_control.sv
// Byte-wide synchronous serial port with control, status and data registers
// on an AHB-Lite slave port.
// Assumes serial pins are synchronous to REF_CLK; one slave on the bus.
// Function
// - Interrupt raised on done or mode fault when interrupt enable is set.
// - Pin enable hands pins to the serial port; reset clears it.
// - Slave select low in master role clears pin enable and master select.
// - Master select drives serial clock out and swaps data pin directions.
// - Idle level bit sets serial clock steady level in master role only; slave capture ignores it.
// - Phase bit picks first or second transition as first capture.
// - Master clock divides system clock by 2, 8, 16, 32, 64, 128.
// - Rate bits have no effect in slave role.
// - Done flag set at byte end; cleared by status access then data access.
// - Data writes ignored while done flag stands and no status access has followed it.
// - Data write during shifting sets collision flag and is discarded.
// - Mode fault set on select low as master; cleared by status then control write.
// - In master role only a data write starts the next byte.
// - Received byte copied to receive buffer at byte end; data reads return it.
// - Data write loads the shift register directly.
// - Upper control bits and all status bits are zero after reset.
// - Collision flag never raises the interrupt.
// - Collision flag cleared by status read then data read, not data write.
// - With mode fault set and no status access since, pin enable and master select cannot be set.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "spi_ctl_consts.svh"

module spi_register_control (
	input wire logic REF_CLK, // System clock, 100 MHz
	input wire logic NRST, // Asynchronous reset, active low
	input wire logic HSEL, // Slave select
	input wire logic [31:0] HADDR, // Byte address
	input wire logic [1:0] HTRANS, // Transfer type
	input wire logic HWRITE, // Write when high
	input wire logic [2:0] HSIZE, // Transfer size
	input wire logic [31:0] HWDATA, // Write data
	input wire logic HREADY, // Bus ready
	output logic [31:0] HRDATA, // Read data
	output logic HREADYOUT, // Slave ready
	output logic HRESP, // Response, always OKAY
	input wire logic SCK_I, // Serial clock in
	output logic SCK_O, // Serial clock out
	output logic SCK_OE, // Serial clock drive enable
	input wire logic MOSI_I, // Master-out line in
	output logic MOSI_O, // Master-out line out
	output logic MOSI_OE, // Master-out drive enable
	input wire logic MISO_I, // Master-in line in
	output logic MISO_O, // Master-in line out
	output logic MISO_OE, // Master-in drive enable
	input wire logic SS_N, // Slave select, active low
	output logic IRQ // Serial interrupt, active high
);

	// ======================================================================
	// Decoding helpers
	function automatic spi_ctl_pkg::reg_sel_t decode_sel(input logic [31:0] addr);
		decode_sel = spi_ctl_pkg::SEL_NONE;
		if (addr[31:10] == 22'h0 && addr[1:0] == 2'h0) begin
			if (addr[9:2] == `SPI_IDX_DATA)
				decode_sel = spi_ctl_pkg::SEL_DATA;
			else if (addr[9:2] == `SPI_IDX_CTRL)
				decode_sel = spi_ctl_pkg::SEL_CTRL;
			else if (addr[9:2] == `SPI_IDX_STAT)
				decode_sel = spi_ctl_pkg::SEL_STAT;
		end
	endfunction

	function automatic logic [6:0] half_period(input logic [2:0] rate);
		logic [7:0] div;
		div = `SPI_DIV_000;
		case (rate)
			3'h4: div = `SPI_DIV_100;
			3'h1: div = `SPI_DIV_001;
			3'h6: div = `SPI_DIV_110;
			3'h2: div = `SPI_DIV_010;
			3'h3: div = `SPI_DIV_011;
			default: div = `SPI_DIV_000;
		endcase
		half_period = div[7:1];
	endfunction

	// ======================================================================
	// Registers
	logic irq_enable, pin_enable, rate_select_high, master_select;
	logic clock_idle_level, clock_capture_phase, rate_select_mid, rate_select_low;
	logic transfer_done_flag, write_collision_flag, mode_fault_flag;
	logic done_armed, write_collision_flag_armed, mode_fault_flag_armed;
	logic [7:0] rx_buffer, shreg;
	logic out_bit, sck_prev;
	logic [3:0] edge_cnt;
	spi_ctl_pkg::xfer_state_t state;
	logic wr_pend;
	spi_ctl_pkg::reg_sel_t wr_sel;

	// ======================================================================
	// Bus slave
	logic addr_ok;
	spi_ctl_pkg::reg_sel_t addr_sel;
	logic data_rd, stat_rd, data_wr, ctrl_wr, stat_wr;
	logic [7:0] rd_byte, wbyte;

	assign addr_ok = HSEL && HTRANS[1] && HREADY;
	assign addr_sel = decode_sel(HADDR);
	assign data_rd = addr_ok && !HWRITE && addr_sel == spi_ctl_pkg::SEL_DATA;
	assign stat_rd = addr_ok && !HWRITE && addr_sel == spi_ctl_pkg::SEL_STAT;
	assign data_wr = wr_pend && wr_sel == spi_ctl_pkg::SEL_DATA;
	assign ctrl_wr = wr_pend && wr_sel == spi_ctl_pkg::SEL_CTRL;
	assign stat_wr = wr_pend && wr_sel == spi_ctl_pkg::SEL_STAT;
	assign wbyte = HWDATA[7:0];

	always_comb begin
		rd_byte = 8'h00;
		unique case (addr_sel)
			spi_ctl_pkg::SEL_DATA: rd_byte = rx_buffer;
			spi_ctl_pkg::SEL_CTRL: rd_byte = {irq_enable, pin_enable, rate_select_high,
				master_select, clock_idle_level, clock_capture_phase,
				rate_select_mid, rate_select_low};
			spi_ctl_pkg::SEL_STAT: rd_byte = {transfer_done_flag, write_collision_flag,
				1'b0, mode_fault_flag, 4'h0};
			spi_ctl_pkg::SEL_NONE: rd_byte = 8'h00;
		endcase
	end

	// Zero wait states: read data is sampled at the address edge
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			HRDATA <= 32'h0;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			wr_pend <= 1'b0;
			wr_sel <= spi_ctl_pkg::SEL_NONE;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			wr_pend <= addr_ok && HWRITE;
			wr_sel <= addr_sel;
			if (addr_ok && !HWRITE)
				HRDATA <= {24'h0, rd_byte};
		end
	end

	// ======================================================================
	// Transfer engine
	logic busy, ev, capture, done, mode_fault_flag_set, accept, dr_load, write_collision_flag_set, rx_in;
	logic div_tick;
	logic [7:0] next_shreg;

	assign busy = state != spi_ctl_pkg::XFER_IDLE;
	assign mode_fault_flag_set = master_select && !SS_N;
	assign accept = !transfer_done_flag || done_armed;
	assign dr_load = data_wr && accept && !busy;
	assign write_collision_flag_set = data_wr && accept && busy;
	assign rx_in = master_select ? MISO_I : MOSI_I;
	assign next_shreg = {shreg[6:0], rx_in};
	assign ev = (state == spi_ctl_pkg::XFER_MASTER && div_tick) ||
		(state == spi_ctl_pkg::XFER_SLAVE && SCK_I != sck_prev);
	assign capture = ev && (edge_cnt[0] == clock_capture_phase);
	assign done = ev && edge_cnt == `SPI_LAST_EDGE;

	sck_divider #(.W(7)) u_div (
		.clk(REF_CLK),
		.rst_n(NRST),
		.run(state == spi_ctl_pkg::XFER_MASTER),
		.half(half_period({rate_select_high, rate_select_mid, rate_select_low})),
		.tick(div_tick)
	);

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST)
			sck_prev <= 1'b0;
		else
			sck_prev <= SCK_I;
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			state <= spi_ctl_pkg::XFER_IDLE;
			shreg <= `SPI_DATA_RESET;
			out_bit <= 1'b0;
			edge_cnt <= 4'h0;
			SCK_O <= 1'b0;
		end else if (mode_fault_flag_set) begin
			state <= spi_ctl_pkg::XFER_IDLE;
			edge_cnt <= 4'h0;
			SCK_O <= clock_idle_level;
		end else begin
			unique case (state)
				spi_ctl_pkg::XFER_IDLE: begin
					SCK_O <= clock_idle_level;
					edge_cnt <= 4'h0;
					if (dr_load) begin
						shreg <= wbyte;
						out_bit <= wbyte[7];
						if (pin_enable && master_select)
							state <= spi_ctl_pkg::XFER_MASTER;
					end else if (pin_enable && !master_select && !SS_N) begin
						state <= spi_ctl_pkg::XFER_SLAVE;
					end
				end
				spi_ctl_pkg::XFER_MASTER: begin
					if (ev) begin
						SCK_O <= !SCK_O;
						edge_cnt <= edge_cnt + 4'h1;
						if (capture)
							shreg <= next_shreg;
						else
							out_bit <= shreg[7];
						if (done)
							state <= spi_ctl_pkg::XFER_IDLE;
					end
				end
				spi_ctl_pkg::XFER_SLAVE: begin
					SCK_O <= clock_idle_level;
					if (SS_N || !pin_enable || master_select) begin
						state <= spi_ctl_pkg::XFER_IDLE;
						edge_cnt <= 4'h0;
					end else if (ev) begin
						edge_cnt <= edge_cnt + 4'h1;
						if (capture)
							shreg <= next_shreg;
						else
							out_bit <= shreg[7];
						if (done)
							state <= spi_ctl_pkg::XFER_IDLE;
					end
				end
				default: state <= spi_ctl_pkg::XFER_IDLE;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST)
			rx_buffer <= `SPI_DATA_RESET;
		else if (done)
			rx_buffer <= capture ? next_shreg : shreg;
	end

	// ======================================================================
	// Control register
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			{irq_enable, pin_enable, rate_select_high, master_select,
				clock_idle_level, clock_capture_phase, rate_select_mid,
				rate_select_low} <= `SPI_CTRL_RESET;
		end else begin
			if (ctrl_wr) begin
				irq_enable <= wbyte[`SPI_CTRL_IRQ_EN];
				rate_select_high <= wbyte[`SPI_CTRL_RATE_HI];
				clock_idle_level <= wbyte[`SPI_CTRL_IDLE_LVL];
				clock_capture_phase <= wbyte[`SPI_CTRL_PHASE];
				rate_select_mid <= wbyte[`SPI_CTRL_RATE_MID];
				rate_select_low <= wbyte[`SPI_CTRL_RATE_LO];
			end
			if (mode_fault_flag_set) begin
				pin_enable <= 1'b0;
				master_select <= 1'b0;
			end else if (ctrl_wr) begin
				pin_enable <= wbyte[`SPI_CTRL_PIN_EN] && (!mode_fault_flag || mode_fault_flag_armed);
				master_select <= wbyte[`SPI_CTRL_MASTER] && (!mode_fault_flag || mode_fault_flag_armed);
			end
		end
	end

	// ======================================================================
	// Status flags; a set in the clearing cycle wins
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			transfer_done_flag <= 1'b0;
			done_armed <= 1'b0;
		end else if (done) begin
			transfer_done_flag <= 1'b1;
			done_armed <= 1'b0;
		end else if (done_armed && (data_rd || data_wr)) begin
			transfer_done_flag <= 1'b0;
			done_armed <= 1'b0;
		end else if (transfer_done_flag && (stat_rd || stat_wr)) begin
			done_armed <= 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			write_collision_flag <= 1'b0;
			write_collision_flag_armed <= 1'b0;
		end else if (write_collision_flag_set) begin
			write_collision_flag <= 1'b1;
			write_collision_flag_armed <= 1'b0;
		end else if (write_collision_flag_armed && data_rd) begin
			write_collision_flag <= 1'b0;
			write_collision_flag_armed <= 1'b0;
		end else if (write_collision_flag && stat_rd) begin
			write_collision_flag_armed <= 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			mode_fault_flag <= 1'b0;
			mode_fault_flag_armed <= 1'b0;
		end else if (mode_fault_flag_set) begin
			mode_fault_flag <= 1'b1;
			mode_fault_flag_armed <= 1'b0;
		end else if (mode_fault_flag_armed && ctrl_wr) begin
			mode_fault_flag <= 1'b0;
			mode_fault_flag_armed <= 1'b0;
		end else if (mode_fault_flag && (stat_rd || stat_wr)) begin
			mode_fault_flag_armed <= 1'b1;
		end
	end

	// ======================================================================
	// Pin drive and interrupt
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			SCK_OE <= 1'b0;
			MOSI_OE <= 1'b0;
			MISO_OE <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			SCK_OE <= pin_enable && master_select && !mode_fault_flag_set;
			MOSI_OE <= pin_enable && master_select && !mode_fault_flag_set;
			MISO_OE <= pin_enable && !master_select && !SS_N;
			IRQ <= irq_enable && (transfer_done_flag || mode_fault_flag);
		end
	end

	// One shift output feeds whichever data line the role drives
	assign MOSI_O = out_bit;
	assign MISO_O = out_bit;

endmodule // spi_register_control

`default_nettype wire

// File: spi_register_control_props.sv
// Concurrent checks for the serial control block.
// Assumes it sees only the top module's ports; bound below.
`timescale 1ns/1ps
`default_nettype none

module spi_register_control_props (
	input wire logic REF_CLK, // Clock
	input wire logic NRST, // Reset, active low
	input wire logic [31:0] HRDATA, // Read data
	input wire logic HREADYOUT, // Slave ready
	input wire logic HRESP, // Response
	input wire logic SCK_O, // Serial clock out
	input wire logic SCK_OE, // Clock drive enable
	input wire logic MOSI_OE, // Master-out enable
	input wire logic MISO_OE, // Master-in enable
	input wire logic SS_N, // Select, active low
	input wire logic IRQ // Interrupt
);
	logic sck_q;
	logic [7:0] run_len;
	logic [7:0] prev_len;
	logic [3:0] nt;

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	// ==========================================================
	// Clock half lengths
	// Counts restart while the clock is undriven, so idle gaps are never compared
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			sck_q <= 1'b0;
			run_len <= 8'h00;
			prev_len <= 8'h00;
			nt <= 4'h0;
		end else begin
			sck_q <= SCK_O;
			if (!SCK_OE) begin
				nt <= 4'h0;
				run_len <= 8'h00;
			end else if (SCK_O != sck_q) begin
				prev_len <= run_len;
				run_len <= 8'h01;
				nt <= nt + 4'h1;
			end else if (run_len != 8'hff) begin
				run_len <= run_len + 8'h01;
			end
		end
	end

	// ==========================================================
	// Assertions
	a_bus_okay: assert property (HREADYOUT && !HRESP && HRDATA[31:8] == 24'h0)
		else $error("bus answer or upper read bits wrong");
	a_reset_quiet: assert property ($rose(NRST) |-> !IRQ && !SCK_OE && !MISO_OE)
		else $error("outputs active after reset");
	a_fault_release: assert property (SCK_OE && !SS_N |-> ##[1:3] !SCK_OE)
		else $error("clock still driven after mode fault");
	a_clk_data_pair: assert property (SCK_OE == MOSI_OE)
		else $error("clock and master-out enables differ");
	a_no_contention: assert property (!(MOSI_OE && MISO_OE))
		else $error("both data lines driven");
	a_miso_selected: assert property (MISO_OE |-> !SS_N || !$past(SS_N) || !$past(SS_N, 2))
		else $error("master-in driven while unselected");
	a_equal_halves: assert property (SCK_O != sck_q && nt >= 4'h2 |-> run_len == prev_len)
		else $error("serial clock halves differ");
	a_half_bound: assert property (SCK_O != sck_q && nt != 4'h0 |-> run_len <= 8'h40)
		else $error("serial clock half too long");
	a_irq_byte_end: assert property ($rose(IRQ) && SCK_OE |-> nt == 4'h0)
		else $error("interrupt in mid byte");
endmodule // spi_register_control_props

bind spi_register_control spi_register_control_props u_props (.REF_CLK(REF_CLK), .NRST(NRST),
	.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SCK_O(SCK_O), .SCK_OE(SCK_OE),
	.MOSI_OE(MOSI_OE), .MISO_OE(MISO_OE), .SS_N(SS_N), .IRQ(IRQ));

`default_nettype wire

// File: spi_far_slave.sv
// Far-side serial slave model: returns a byte, captures the master's byte.
// Assumes the bench drives select, phase and the byte to return.
`timescale 1ns/1ps
`default_nettype none

module spi_far_slave (
	input wire logic clk, // System clock
	input wire logic sel_n, // Select, active low
	input wire logic pha, // Capture on second transition
	input wire logic sck, // Serial clock wire
	input wire logic mosi, // Data from master
	input wire logic [7:0] tx, // Byte to return
	output logic miso, // Data to master
	output logic [7:0] rx // Byte captured
);
	logic [7:0] sh = 8'h00;
	logic [3:0] k = 4'h0;
	logic junk = 1'b0;
	logic sck_seen = 1'b0;

	// Released line shows a changing pattern, never a stale bit
	always @(posedge clk) junk <= ~junk;
	assign miso = sel_n ? junk : sh[7];

	// One process owns the shifter: reload while deselected, shift while selected
	// count transitions from rest
	always @(sel_n or sck or tx) begin
		if (sel_n) begin
			k = 4'h0;
			sh = tx;
		end else if (sck !== sck_seen) begin
			if (k[0] == pha) rx = {rx[6:0], mosi};
			else if (!(pha && k == 4'h0)) sh = sh << 1;
			k = k + 4'h1;
		end
		sck_seen = sck;
	end
endmodule // spi_far_slave

`default_nettype wire

// File: tb_spi_register_control.sv
// Self-checking bench for the serial control block.
// Assumes the design, its checker and the far slave model are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "spi_ctl_consts.svh"

module tb_spi_register_control;
	localparam logic [7:0] ix_dat = `SPI_IDX_DATA;
	localparam logic [7:0] ix_ctl = `SPI_IDX_CTRL;
	localparam logic [7:0] ix_sta = `SPI_IDX_STAT;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic ss_n = 1'b1;
	logic sel_n = 1'b1;
	logic pha = 1'b0;
	logic [7:0] tx = 8'h00;
	logic ext_sck = 1'b0;
	logic ext_mosi = 1'b0;
	logic [31:0] hrdata;
	logic [7:0] rx;
	logic hready, hresp, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, far_miso, irq;
	logic sck_w, mosi_w, miso_w;
	int n_errors = 0;
	int tests_run = 0;

	always #5 clk = ~clk;
	assign sck_w = sck_oe ? sck : ext_sck;
	assign mosi_w = mosi_oe ? mosi : ext_mosi;
	assign miso_w = miso_oe ? miso : far_miso;

	spi_register_control DUT (.REF_CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
		.HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .SCK_I(sck_w), .SCK_O(sck),
		.SCK_OE(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi), .MOSI_OE(mosi_oe), .MISO_I(miso_w),
		.MISO_O(miso), .MISO_OE(miso_oe), .SS_N(ss_n), .IRQ(irq));
	spi_far_slave u_far (.clk(clk), .sel_n(sel_n), .pha(pha), .sck(sck_w), .mosi(mosi_w),
		.tx(tx), .miso(far_miso), .rx(rx));

	// ==========================================================
	// Shared tasks
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask

	// Entered just after a rising edge; returns at the data-phase edge
	task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d,
			output logic [7:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, ix, 2'b00};
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		r = hrdata[7:0];
	endtask

	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		logic [7:0] v;
		bus(1'b1, ix, d, v);
	endtask

	task automatic rchk(input string w, input logic [7:0] ix, input logic [7:0] e);
		logic [7:0] v;
		bus(1'b0, ix, 8'h00, v);
		chk(w, e, v);
	endtask

	// Counts 16 clock transitions; h is the gap between the 2nd and 3rd
	task automatic wait_byte(output int h);
		int n;
		int c;
		logic s;
		n = 0;
		c = 0;
		s = sck;
		while (n < 16 && c < 400) begin
			@(posedge clk);
			c++;
			if (sck !== s) begin
				n++;
				if (n == 3) h = c;
				c = 0;
				s = sck;
			end
		end
		repeat (3) @(posedge clk);
	endtask

	task automatic xfer(input logic [7:0] ctl, input logic [7:0] d, input logic [7:0] s,
			input int hv);
		int h;
		pha = ctl[2];
		tx = s;
		wr(ix_ctl, ctl & 8'h2f);
		repeat (2) @(posedge clk);
		chk("idle clock", {7'h0, ctl[3]}, {7'h0, sck});
		wr(ix_ctl, ctl);
		repeat (2) @(posedge clk);
		sel_n = 1'b0;
		wr(ix_dat, d);
		wait_byte(h);
		sel_n = 1'b1;
		chk("half period", hv[7:0], h[7:0]);
		chk("far byte", d, rx);
		chk("irq", {7'h0, ctl[7]}, {7'h0, irq});
		rchk("status", ix_sta, 8'h80);
		rchk("data", ix_dat, s);
		rchk("status", ix_sta, 8'h00);
		chk("irq", 8'h00, {7'h0, irq});
		chk("idle clock", {7'h0, ctl[3]}, {7'h0, sck});
	endtask

	// ==========================================================
	// Scenarios
	task automatic s_reset();
		chk("drive", 8'h00, {6'h0, sck_oe, irq});
		rchk("control", ix_ctl, 8'h00);
		rchk("status", ix_sta, 8'h00);
		rchk("data", ix_dat, 8'h00);
		rchk("unmapped", 8'h20, 8'h00);
	endtask

	task automatic s_rates();
		logic [2:0] code [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
		int div [6] = '{2, 8, 16, 32, 64, 128};
		for (int i = 0; i < 6; i++) begin
			xfer(8'h50 | {2'b0, code[i][2], 3'b0, code[i][1:0]}, 8'ha5 ^ 8'(i), 8'h3c + 8'(i),
				div[i] / 2);
		end
	endtask

	task automatic s_modes();
		for (int m = 0; m < 4; m++) begin
			xfer(8'hd0 | 8'(m << 2), 8'hc3 ^ 8'(m), 8'h69 ^ 8'(m), 4);
		end
	endtask

	task automatic s_collide();
		int h;
		pha = 1'b0;
		tx = 8'h81;
		wr(ix_ctl, 8'h00);
		wr(ix_ctl, 8'hd0);
		sel_n = 1'b0;
		wr(ix_dat, 8'h96);
		repeat (20) @(posedge clk);
		wr(ix_dat, 8'h11);
		repeat (2) @(posedge clk);
		chk("irq", 8'h00, {7'h0, irq});
		rchk("status", ix_sta, 8'h40);
		for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clk);
		sel_n = 1'b1;
		chk("far byte", 8'h96, rx);
		wr(ix_dat, 8'h22);
		repeat (12) @(posedge clk);
		chk("idle clock", 8'h00, {7'h0, sck});
		rchk("status", ix_sta, 8'hc0);
		sel_n = 1'b0;
		wr(ix_dat, 8'h5a);
		wait_byte(h);
		sel_n = 1'b1;
		chk("far byte", 8'h5a, rx);
		rchk("status", ix_sta, 8'hc0);
		rchk("data", ix_dat, 8'h81);
		rchk("status", ix_sta, 8'h00);
	endtask

	task automatic s_fault();
		wr(ix_ctl, 8'h00);
		wr(ix_ctl, 8'hd0);
		repeat (2) @(posedge clk);
		chk("master drive", 8'h03, {6'h0, mosi_oe, sck_oe});
		ss_n <= 1'b0;
		repeat (4) @(posedge clk);
		ss_n <= 1'b1;
		rchk("control", ix_ctl, 8'h80);
		chk("irq", 8'h01, {7'h0, irq});
		wr(ix_ctl, 8'hd0);
		rchk("control", ix_ctl, 8'h80);
		rchk("status", ix_sta, 8'h10);
		wr(ix_ctl, 8'hd0);
		rchk("status", ix_sta, 8'h00);
		rchk("control", ix_ctl, 8'hd0);
		wr(ix_ctl, 8'h40);
		ss_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk("slave drive", 8'h02, {6'h0, miso_oe, sck_oe});
		ss_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("slave drive", 8'h00, {6'h0, miso_oe, sck_oe});
		wr(ix_ctl, 8'h00);
	endtask

	// Bench acts as the far master; rate bits set to the slowest code
	task automatic s_slave();
		logic [7:0] m;
		logic [7:0] got;
		m = 8'h6d;
		got = 8'h00;
		wr(ix_ctl, 8'h43);
		wr(ix_dat, 8'hb4);
		ss_n <= 1'b0;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			ext_mosi <= m[7];
			m = m << 1;
			repeat (2) @(posedge clk);
			got = {got[6:0], miso_w};
			ext_sck <= 1'b1;
			repeat (2) @(posedge clk);
			ext_sck <= 1'b0;
			repeat (2) @(posedge clk);
		end
		chk("slave out byte", 8'hb4, got);
		rchk("status", ix_sta, 8'h80);
		rchk("data", ix_dat, 8'h6d);
		ss_n <= 1'b1;
		wr(ix_ctl, 8'h00);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		s_reset();
		s_rates();
		s_modes();
		s_collide();
		s_fault();
		s_slave();
		tally_and_finish();
	end

	// Whole run is under ten thousand cycles
	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		tally_and_finish();
	end
endmodule // tb_spi_register_control

`default_nettype wire
